/* bench/pin_source.sv */
/*
 * far-side model: an external count input and a secondary oscillator.
 * assumes pclk of 100 ns; each driven pin gives one rising edge per 16 pclk.
 */
`timescale 1ns/100ps
module pin_source (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] drive,
    output logic            ext_clk_pin,
    output logic            osc_clk_pin
);
    logic [2:0] div_r;   // half-period divider
    logic       wave_r;  // square wave, parked low when idle

    // toggle every 8 pclk; a pin not driven stands still at low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r  <= 3'h0;
            wave_r <= 1'b0;
        end else begin
            div_r <= div_r + 3'h1;
            if (div_r == 3'h7) begin
                wave_r <= (drive != 2'h0) ? ~wave_r : 1'b0;
            end
        end
    end

    assign ext_clk_pin = drive[0] & wave_r;
    assign osc_clk_pin = drive[1] & wave_r;
endmodule // pin_source

/* bench/timer_ext_test.sv */
/*
 * self-checking bench for the timer: apb tasks, register sequences.
 * assumes the package offsets and a pin_source model on both count pins.
 */
`timescale 1ns/100ps
module timer_ext_test;
    import timer_ext_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat, keep;
    logic        rerr, ext_clk_pin, osc_clk_pin;
    logic [1:0]  drive;
    int          fail_count, num_checks;

    timer_ext timer_ext_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_clk_pin(ext_clk_pin), .osc_clk_pin(osc_clk_pin), .irq(irq));
    pin_source pin_source_i (.pclk(pclk), .presetn(presetn), .drive(drive),
        .ext_clk_pin(ext_clk_pin), .osc_clk_pin(osc_clk_pin));

    // 10 MHz clock
    always #50 pclk = ~pclk;

    task automatic bad(input string msg);
        fail_count++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) bad($sformatf("got %h want %h", got, exp));
    endtask

    // range check: used where the free-running divider blurs the phase
    task automatic check_rng(input logic [31:0] got, input logic [31:0] lo,
                             input logic [31:0] hi);
        num_checks++;
        if ($isunknown(got) || got < lo || got > hi) bad($sformatf("got %h", got));
    endtask

    // one apb transfer; waits for pready with no bound of its own
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdat, exp);
    endtask

    task automatic rrng(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
        apb(1'b0, a, 32'h0);
        check_rng(rdat, lo, hi);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, fail_count);
    endtask

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 30000 cycles
    initial begin
        repeat (30000) @(posedge pclk);
        bad("timeout");
        print_verdict;
    end

    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; drive = 2'h0; fail_count = 0; num_checks = 0;
        tick(2);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, unmapped address
        rchk(OFS_CTRL, 32'h0);
        rchk(OFS_REQ, 32'h0);
        rchk(OFS_VAL1, 32'hffff);
        rchk(OFS_VAL2, 32'hffff);
        rchk(8'h40, 32'h0);
        check({31'h0, rerr}, 32'h1);
        end_test("reset");
        // atomic access through the high-byte buffer, counter stopped
        wr(OFS_CTRL, 32'h80);
        wr(OFS_HIGH, 32'h34);
        rchk(OFS_HIGH, 32'h34);
        rchk(OFS_LOW, 32'h0);
        rchk(OFS_HIGH, 32'h0);
        wr(OFS_HIGH, 32'h34);
        wr(OFS_LOW, 32'h56);
        wr(OFS_CTRL, 32'h0);
        rchk(OFS_HIGH, 32'h34);
        wr(OFS_CTRL, 32'h80);
        wr(OFS_HIGH, 32'h99);
        wr(OFS_CTRL, 32'h0);
        rchk(OFS_HIGH, 32'h34);
        wr(OFS_HIGH, 32'h12);
        rchk(OFS_HIGH, 32'h12);
        end_test("atomic");
        // prescale codes over a fixed window of 260 pclk
        for (int k = 0; k < 4; k++) begin
            wr(OFS_HIGH, 32'h0);
            wr(OFS_LOW, 32'h0);
            wr(OFS_CTRL, 32'(1 + (k << 4)));
            tick(256);
            wr(OFS_CTRL, 32'h0);
            rrng(OFS_LOW, 32'(260 / (4 << k)) - 1, 32'(260 / (4 << k)) + 1);
            keep = rdat;
            tick(40);
            rchk(OFS_LOW, keep);
        end
        end_test("prescale");
        // wrap with the interrupt masked, then unmasked, then cleared
        wr(OFS_HIGH, 32'hff);
        wr(OFS_LOW, 32'hfe);
        wr(OFS_CTRL, 32'h1);
        tick(40);
        wr(OFS_CTRL, 32'h0);
        rchk(OFS_HIGH, 32'h0);
        rchk(OFS_REQ, 32'h2);
        check({31'h0, irq}, 32'h0);
        wr(OFS_ENA, 32'h2);
        tick(3);
        check({31'h0, irq}, 32'h1);
        rchk(OFS_REQ, 32'h2);
        wr(OFS_REQ, 32'h2);
        tick(3);
        check({31'h0, irq}, 32'h0);
        end_test("overflow");
        // pin edges: sync, no sync, then the oscillator (20 edges each)
        for (int i = 0; i < 3; i++) begin
            wr(OFS_LOW, 32'h0);
            wr(OFS_COMPANION, (i == 2) ? 32'h8 : 32'h0);
            wr(OFS_CTRL, (i == 1) ? 32'h7 : 32'h3);
            drive <= (i == 2) ? 2'h2 : 2'h1;
            tick(320);
            drive <= 2'h0;
            tick(20);
            rrng(OFS_LOW, 32'd19, 32'd21);
        end
        wr(OFS_COMPANION, 32'h0);
        end_test("pins");
        // compare trigger as period, units one and two
        wr(OFS_CTRL, 32'h0);
        wr(OFS_LOW, 32'h0);
        wr(OFS_MODE1, {28'h0, MODE_TRIGGER});
        wr(OFS_VAL1, 32'h5);
        wr(OFS_CTRL, 32'h49);
        tick(100);
        rrng(OFS_LOW, 32'h0, 32'h5);
        rchk(OFS_HIGH, 32'h0);
        rchk(OFS_REQ, 32'h0);
        wr(OFS_MODE1, 32'h0);
        // stop and restart from zero so the count starts below the new period
        wr(OFS_CTRL, 32'h8);
        wr(OFS_LOW, 32'h0);
        wr(OFS_MODE2, {28'h0, MODE_TRIGGER});
        wr(OFS_VAL2, 32'h3);
        wr(OFS_CTRL, 32'h9);
        tick(60);
        rrng(OFS_LOW, 32'h0, 32'h3);
        // write collides with a standing trigger: the write wins
        wr(OFS_CTRL, 32'h48);
        wr(OFS_MODE1, {28'h0, MODE_TRIGGER});
        wr(OFS_VAL1, 32'h0);
        wr(OFS_LOW, 32'h0);
        wr(OFS_LOW, 32'h77);
        rchk(OFS_LOW, 32'h77);
        end_test("trigger");
        print_verdict;
    end
endmodule // timer_ext_test

/* rtl/pin_edge_sync.sv */
/*
 * two-flop synchroniser and rising-edge detector for a pin input.
 * assumes the pin is asynchronous to pclk and slower than pclk / 2.
 */
`timescale 1ns/100ps
module pin_edge_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      rise
);
    logic meta_r;   // first stage, read only by sync_r
    logic sync_r;   // second stage
    logic last_r;   // previous synchronised level

    // synchroniser chain plus history for the edge detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // one-cycle pulse on a synchronised rising edge
    assign rise = sync_r & ~last_r;
endmodule // pin_edge_sync

/* rtl/timer_ext.sv */
/*
 * 16-bit timer/counter with atomic byte access, prescaler, external or
 * oscillator clock, overflow interrupt and compare trigger reset.
 * assumes an apb master on pclk, async pins, and compare units whose
 * mode and value registers live here for the trigger check.
 */
`timescale 1ns/100ps
module timer_ext (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_clk_pin,
    input  wire logic        osc_clk_pin,
    output logic             irq
);
    import timer_ext_pkg::*;

    logic [7:0]  ctrl_r;       // timer_control
    logic [7:0]  companion_r;  // companion_timer_control
    logic [15:0] count_r;      // live counter
    logic [7:0]  hi_buf_r;     // high-byte buffer
    logic [2:0]  pre_r;        // input prescaler
    logic [1:0]  div_r;        // instruction cycle divider
    logic        pend_r;       // external edge awaiting alignment
    logic        ovf_flag_r;   // overflow_flag
    logic        ovf_en_r;     // overflow_irq_enable
    logic [3:0]  mode_r [2];   // compare_unit_mode_field per unit
    logic [15:0] cval_r [2];   // compare_value_pair per unit
    logic [31:0] rd_mux;       // read data selection
    logic [2:0]  ps_mask;      // prescale terminal mask
    logic [1:0]  uses;         // unit is assigned to this timer
    logic [1:0]  trig_u;       // per-unit trigger

    // control field views
    wire atomic  = ctrl_r[CTL_ATOMIC];
    wire run     = ctrl_r[CTL_RUN];
    wire cs      = ctrl_r[CTL_CS];
    wire nosync  = ctrl_r[CTL_NOSYNC];
    wire osc_en  = companion_r[OSC_EN_BIT];
    wire [1:0] ps   = ctrl_r[CTL_PS_LO +: 2];
    wire [1:0] asgn = {ctrl_r[CTL_ASGN_HI], ctrl_r[CTL_ASGN_LO]};

    // apb phases: capture edge sets pready, done edge completes
    wire capture = psel & penable & ~pready;
    wire done    = psel & penable & pready;
    wire wr_done = done & pwrite;
    wire rd_cap  = capture & ~pwrite;

    // address hits
    wire hit_low  = (paddr == OFS_LOW);
    wire hit_high = (paddr == OFS_HIGH);
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_req  = (paddr == OFS_REQ);
    wire hit_ena  = (paddr == OFS_ENA);
    wire hit_comp = (paddr == OFS_COMPANION);
    wire mapped   = hit_low | hit_high | hit_ctrl | hit_req | hit_ena | hit_comp
                  | (paddr == OFS_MODE1) | (paddr == OFS_VAL1)
                  | (paddr == OFS_MODE2) | (paddr == OFS_VAL2);

    // writes that move the counter itself
    wire wr_low   = wr_done & hit_low;
    wire wr_high  = wr_done & hit_high;
    wire cnt_write = wr_low | (wr_high & ~atomic);

    // clock source selection and edge detection
    wire ext_pin = osc_en ? osc_clk_pin : ext_clk_pin;  // RL6
    wire ext_rise;

    pin_edge_sync u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (ext_pin),
        .rise    (ext_rise)
    );

    wire instr_tick = (div_r == DIV_LAST);
    // sync mode waits for the instruction boundary, raw mode does not
    wire src_event  = !cs ? instr_tick :                      // RL15
                      (nosync ? ext_rise : (pend_r & instr_tick)); // RL18
    wire count_en   = run & src_event;                        // RL17

    // prescale mask: counting tick when all masked bits are set
    always_comb begin
        case (ps)
            2'b00:   ps_mask = 3'h0;
            2'b01:   ps_mask = 3'h1;
            2'b10:   ps_mask = 3'h3;
            default: ps_mask = 3'h7;
        endcase
    end
    wire cnt_tick = count_en & ((pre_r & ps_mask) == ps_mask); // RL16

    // trigger check per compare unit
    generate
        for (genvar i = 0; i < 2; i++) begin : g_unit
            // unit one only with all assigned, unit two also with 01
            assign uses[i] = (asgn == ASGN_ALL) || (i == 1 && asgn == ASGN_TWO);
            assign trig_u[i] = uses[i] && (mode_r[i] == MODE_TRIGGER)
                             && (count_r == cval_r[i]); // RL10 RL12
        end
    endgenerate
    wire trig = |trig_u;
    // only a real wrap of the count sets the flag
    wire wrap = cnt_tick & (count_r == COUNT_MAX) & ~cnt_write & ~trig; // RL14

    // instruction cycle divider, free running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end

    // pending external edge for synchronous counter mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= 1'b0;
        end else begin
            // a new edge wins over the boundary that consumes the old one
            pend_r <= ext_rise | (pend_r & ~instr_tick);
        end
    end

    // prescaler: high-byte writes leave it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= 3'h0;
        end else if (wr_low) begin
            pre_r <= 3'h0; // RL5
        end else if (count_en) begin
            pre_r <= cnt_tick ? 3'h0 : pre_r + 3'h1;
        end
    end

    // counter: write beats trigger, trigger beats counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= COUNT_RST;
        end else if (wr_low) begin
            if (atomic) begin
                count_r <= {hi_buf_r, pwdata[7:0]}; // RL3 RL13
            end else begin
                count_r <= {count_r[15:8], pwdata[7:0]}; // RL13
            end
        end else if (wr_high && !atomic) begin
            count_r <= {pwdata[7:0], count_r[7:0]}; // RL19
        end else if (trig) begin
            count_r <= COUNT_RST; // RL10
        end else if (cnt_tick) begin
            count_r <= count_r + 16'h0001; // RL7
        end
    end

    // high-byte buffer, only active in atomic mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_buf_r <= 8'h00;
        end else if (rd_cap && hit_low && atomic) begin
            // copied at the same edge as the low byte is sampled
            hi_buf_r <= count_r[15:8]; // RL2
        end else if (wr_high && atomic) begin
            hi_buf_r <= pwdata[7:0]; // RL1 RL4
        end
    end

    // overflow flag: set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_flag_r <= 1'b0;
        end else begin
            ovf_flag_r <= wrap | (ovf_flag_r                            // RL7
                        & ~(wr_done & hit_req & pwdata[OVF_BIT]));     // RL8
        end
    end

    // interrupt output is registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= ovf_flag_r & ovf_en_r; // RL9
        end
    end

    // software-written control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r      <= CTRL_RST;
            companion_r <= CTRL_RST;
            ovf_en_r    <= 1'b0;
        end else if (wr_done) begin
            if (hit_ctrl) begin
                ctrl_r <= pwdata[7:0];
            end
            if (hit_comp) begin
                companion_r <= pwdata[7:0];
            end
            if (hit_ena) begin
                ovf_en_r <= pwdata[OVF_BIT];
            end
        end
    end

    // compare unit mode and value registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r[0] <= 4'h0;
            mode_r[1] <= 4'h0;
            cval_r[0] <= CVAL_RST;
            cval_r[1] <= CVAL_RST;
        end else if (wr_done) begin
            if (paddr == OFS_MODE1) begin
                mode_r[0] <= pwdata[3:0];
            end
            if (paddr == OFS_VAL1) begin
                cval_r[0] <= pwdata[15:0];
            end
            if (paddr == OFS_MODE2) begin
                mode_r[1] <= pwdata[3:0];
            end
            if (paddr == OFS_VAL2) begin
                cval_r[1] <= pwdata[15:0];
            end
        end
    end

    // read data selection; unused bits read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFS_LOW:       rd_mux[7:0] = count_r[7:0];
            // atomic mode shows the buffer instead of the live byte
            OFS_HIGH:      rd_mux[7:0] = atomic ? hi_buf_r : count_r[15:8]; // RL1 RL19
            OFS_CTRL:      rd_mux[7:0] = ctrl_r;
            OFS_REQ:       rd_mux[OVF_BIT] = ovf_flag_r;
            OFS_ENA:       rd_mux[OVF_BIT] = ovf_en_r;
            OFS_COMPANION: rd_mux[7:0] = companion_r;
            OFS_MODE1:     rd_mux[3:0] = mode_r[0];
            OFS_VAL1:      rd_mux[15:0] = cval_r[0];
            OFS_MODE2:     rd_mux[3:0] = mode_r[1];
            OFS_VAL2:      rd_mux[15:0] = cval_r[1];
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    // apb answer: one wait state, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= capture;
            pslverr <= capture & ~mapped;
            if (capture) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_low_read;
        rd_cap && hit_low && atomic;
    endsequence

    sequence s_high_read;
        rd_cap && hit_high && atomic;
    endsequence

    a_atomic_high_read: assert property ( // RL1
        s_high_read |=> prdata[7:0] == $past(hi_buf_r))
        else $error("atomic high read did not return buffer");

    a_low_read_copy: assert property ( // RL2
        s_low_read |=> hi_buf_r == $past(count_r[15:8]) && pready)
        else $error("low read did not copy high byte");

    a_low_write_load: assert property ( // RL3
        wr_low && atomic |=> count_r == {$past(hi_buf_r), $past(pwdata[7:0])})
        else $error("atomic low write did not load sixteen bits");

    a_high_write_buf: assert property ( // RL4
        wr_high && atomic && !trig && !cnt_tick
        |=> hi_buf_r == $past(pwdata[7:0]) && $stable(count_r))
        else $error("atomic high write reached live counter");

    a_prescale_clear: assert property ( // RL5
        wr_low |=> pre_r == 3'h0)
        else $error("low write did not clear prescaler");

    // software may clear the flag one cycle after the wrap; that is legal
    a_wrap_flag: assert property ( // RL7
        wrap |=> count_r == COUNT_RST && ovf_flag_r
        ##1 (ovf_flag_r || $past(wr_done && hit_req && pwdata[OVF_BIT])))
        else $error("wrap did not clear count and latch flag");

    a_irq_masked: assert property ( // RL9
        !ovf_en_r && $past(!ovf_en_r) |-> !irq)
        else $error("interrupt raised while disabled");

    a_trig_reset: assert property ( // RL14
        trig && !cnt_write && !ovf_flag_r |=> count_r == COUNT_RST && !ovf_flag_r)
        else $error("trigger reset wrong or set flag");

    a_write_wins: assert property ( // RL13
        trig && wr_low |=> count_r[7:0] == $past(pwdata[7:0]))
        else $error("trigger overrode software write");

    a_stopped_hold: assert property ( // RL17
        !run && !cnt_write && !trig |=> $stable(count_r))
        else $error("counter moved while stopped");

    a_live_high: assert property ( // RL19
        wr_high && !atomic |=> count_r[15:8] == $past(pwdata[7:0]))
        else $error("non-atomic high write lost");

    a_flag_hold: assert property ( // RL8
        ovf_flag_r && !(wr_done && hit_req && pwdata[OVF_BIT]) |=> ovf_flag_r)
        else $error("overflow flag dropped without a clear");

    // an unassigned unit or one in another mode must never reset the count
    a_trig_source: assert property ( // RL10 RL12
        trig |-> (uses[0] && mode_r[0] == MODE_TRIGGER && count_r == cval_r[0])
              || (uses[1] && mode_r[1] == MODE_TRIGGER && count_r == cval_r[1]))
        else $error("trigger without an assigned matching unit");

    a_count_step: assert property ( // RL7
        cnt_tick && !cnt_write && !trig |=> count_r == $past(count_r) + 16'h0001)
        else $error("counter did not step by one");

    a_instr_rate: assert property ( // RL15
        count_en && !cs |-> div_r == DIV_LAST)
        else $error("internal source counted off the instruction boundary");

    a_sync_align: assert property ( // RL18
        count_en && cs && !nosync |-> instr_tick && pend_r)
        else $error("synchronised edge counted unaligned");

    a_prescale_wrap: assert property ( // RL16
        cnt_tick |=> pre_r == 3'h0)
        else $error("prescaler not restarted after a counting tick");
endmodule // timer_ext

/* rtl/timer_ext_pkg.sv */
/*
 * constants for the 16-bit timer/counter with atomic byte access:
 * apb byte offsets, control field positions, reset values, codes.
 * assumes a 32-bit apb master and pclk acting as the oscillator clock.
 */
// Contract
// (RL1) atomic mode maps high address to buffer
// (RL2) atomic low read copies high into buffer
// (RL3) atomic low write loads high from buffer
// (RL4) atomic mode hides live high byte
// (RL5) only low-byte writes clear the prescaler
// (RL6) software enables oscillator and selects external
// (RL7) counter wraps ffff to 0000, sets flag
// (RL8) overflow flag sticky until software clears
// (RL9) interrupt forwarded only when enable set
// (RL10) compare trigger in mode 1011 resets counter
// (RL11) use timer or synchronous mode for triggers
// (RL12) compare value acts as counter period
// (RL13) software write beats trigger reset
// (RL14) trigger reset never sets overflow flag
// (RL15) internal source counts once per instruction
// (RL16) prescale codes divide by 1,2,4,8
// (RL17) run bit starts and stops counting
// (RL18) sync bit chooses aligned or raw edges
// (RL19) non-atomic mode accesses live high byte
package timer_ext_pkg;
    // register byte offsets on apb
    localparam logic [7:0] OFS_LOW       = 8'h00;
    localparam logic [7:0] OFS_HIGH      = 8'h04;
    localparam logic [7:0] OFS_CTRL      = 8'h08;
    localparam logic [7:0] OFS_REQ       = 8'h0c;
    localparam logic [7:0] OFS_ENA       = 8'h10;
    localparam logic [7:0] OFS_COMPANION = 8'h14;
    localparam logic [7:0] OFS_MODE1     = 8'h18;
    localparam logic [7:0] OFS_VAL1      = 8'h1c;
    localparam logic [7:0] OFS_MODE2     = 8'h20;
    localparam logic [7:0] OFS_VAL2      = 8'h24;
    // timer_control field positions
    localparam int CTL_RUN      = 0;
    localparam int CTL_CS       = 1;
    localparam int CTL_NOSYNC   = 2;
    localparam int CTL_ASGN_LO  = 3;
    localparam int CTL_PS_LO    = 4;
    localparam int CTL_ASGN_HI  = 6;
    localparam int CTL_ATOMIC   = 7;
    // companion control and interrupt bit positions
    localparam int OSC_EN_BIT   = 3;
    localparam int OVF_BIT      = 1;
    // reset values
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] CVAL_RST  = 16'hffff;
    // compare unit mode that raises the special event trigger
    localparam logic [3:0]  MODE_TRIGGER = 4'hb;
    // timer assignment codes
    localparam logic [1:0]  ASGN_ALL  = 2'b11;
    localparam logic [1:0]  ASGN_TWO  = 2'b01;
    // instruction cycle is four oscillator clocks
    localparam int          INSTR_DIV = 4;
    localparam logic [1:0]  DIV_LAST  = 2'(INSTR_DIV - 1);
endpackage
